// ---- core/fsc_regs.vh ----
// Register offsets, field positions and reset values for the fault status capture block
`ifndef FSC_REGS_VH
`define FSC_REGS_VH
`define FSC_OFF_STATUS 12'h000
`define FSC_OFF_BFAR 12'h004
`define FSC_OFF_MMFAR 12'h008
`define FSC_OFF_PEND 12'h00c
`define FSC_OFF_IRQ_STAT 12'h010
`define FSC_OFF_IRQ_MASK 12'h014
`define FSC_OFF_PRIO 12'h018
`define FSC_BIT_STKVIO 4
`define FSC_BIT_MMAV 7
`define FSC_BIT_INSTR_ERR 8
`define FSC_BIT_PRECISE 9
`define FSC_BIT_IMPRECISE 10
`define FSC_STATUS_MASK 16'h0790
`define FSC_STATUS_RST 16'h0000
`define FSC_ADDR_RST 32'h00000000
`define FSC_PRIO_RST 8'h00
`define FSC_MASK_RST 4'h0
`define FSC_IRQ_IMPRECISE 0
`define FSC_IRQ_PRECISE 1
`define FSC_IRQ_INSTR_ERR 2
`define FSC_IRQ_STKVIO 3
`endif

// ---- core/fsc_addr_store.v ----
// Two-word fault address store with registered read port
`timescale 1ns/1ps
`default_nettype none
module fsc_addr_store (
  input wire pclk,
  input wire presetn,
  input wire en,
  input wire we0,
  input wire [31:0] wd0,
  input wire we1,
  input wire [31:0] wd1,
  input wire rsel,
  output reg [31:0] rdata
);
  reg [31:0] word0_r;
  reg [31:0] word1_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word0_r <= 32'h00000000;
      word1_r <= 32'h00000000;
      rdata <= 32'h00000000;
    end else if (en) begin
      if (we0) begin
        word0_r <= wd0;
      end
      if (we1) begin
        word1_r <= wd1;
      end
      rdata <= rsel ? word1_r : word0_r;
    end
  end
endmodule
`default_nettype wire

// ---- core/fsc_fault_status.v ----
// Fault status capture: sticky fault flags, fault addresses, deferred imprecise fault, APB slave
`timescale 1ns/1ps
`default_nettype none
`include "fsc_regs.vh"
// Notes on behaviour
// - Imprecise data bus error sets bit 10.
// - Imprecise error never loads the bus fault address.
// - Imprecise fault waits pending until priority falls below bus fault priority.
// - A precise fault before imprecise handler entry leaves both flags set.
// - Precise data bus error sets bit 9.
// - Precise data bus error loads the faulting address.
// - Instruction bus error sets bit 8 on issue only, no address captured.
// - Bit 7 shows the memory fault address is valid.
// - Bits 6:5 are reserved, read-only zero.
// - Stacking violation sets bit 4, no memory fault address captured.
// - Flags reset to 0, cleared only by writing 1.
module fsc_fault_status (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire dbus_err_imprecise,
  input wire dbus_err_precise,
  input wire [31:0] dbus_err_addr,
  input wire instr_bus_err_flag_err_issue,
  input wire mem_fault,
  input wire [31:0] mem_fault_addr,
  input wire stack_violation,
  input wire [7:0] cur_priority,
  output reg bus_fault_activate,
  output reg imprecise_pending,
  output reg irq
);
  reg [15:0] status_r;
  reg [15:0] status_nxt;
  reg pend_r;
  reg [3:0] istat_r;
  reg [3:0] istat_nxt;
  reg [3:0] imask_r;
  reg [7:0] prio_r;
  wire [31:0] addr_rdata;
  wire setup = psel && !penable;
  wire acc = psel && penable && pready;
  wire wr_acc = acc && pwrite;
  // Higher priority means numerically lower level
  wire may_activate = cur_priority > prio_r;

  function known;
    input [11:0] a;
    begin
      known = (a == `FSC_OFF_STATUS) || (a == `FSC_OFF_BFAR) || (a == `FSC_OFF_MMFAR) ||
              (a == `FSC_OFF_PEND) || (a == `FSC_OFF_IRQ_STAT) || (a == `FSC_OFF_IRQ_MASK) ||
              (a == `FSC_OFF_PRIO);
    end
  endfunction

  fsc_addr_store u_store (
    .pclk(pclk),
    .presetn(presetn),
    .en(clk_en),
    .we0(dbus_err_precise),
    .wd0(dbus_err_addr),
    .we1(mem_fault && !stack_violation),
    .wd1(mem_fault_addr),
    .rsel(paddr == `FSC_OFF_MMFAR),
    .rdata(addr_rdata)
  );

  // Set beats clear; write 0 leaves flags alone
  always @* begin
    status_nxt = status_r;
    if (wr_acc && paddr == `FSC_OFF_STATUS) begin
      status_nxt = status_r & ~(pwdata[15:0] & `FSC_STATUS_MASK);
    end
    if (dbus_err_imprecise) begin
      status_nxt[`FSC_BIT_IMPRECISE] = 1'b1;
    end
    if (dbus_err_precise) begin
      status_nxt[`FSC_BIT_PRECISE] = 1'b1;
    end
    if (instr_bus_err_flag_err_issue) begin
      status_nxt[`FSC_BIT_INSTR_ERR] = 1'b1;
    end
    if (mem_fault && !stack_violation) begin
      status_nxt[`FSC_BIT_MMAV] = 1'b1;
    end
    if (stack_violation) begin
      status_nxt[`FSC_BIT_STKVIO] = 1'b1;
    end
    status_nxt = status_nxt & `FSC_STATUS_MASK;
  end

  always @* begin
    istat_nxt = istat_r;
    if (wr_acc && paddr == `FSC_OFF_IRQ_STAT) begin
      istat_nxt = istat_r & ~pwdata[3:0];
    end
    if (dbus_err_imprecise) begin
      istat_nxt[`FSC_IRQ_IMPRECISE] = 1'b1;
    end
    if (dbus_err_precise) begin
      istat_nxt[`FSC_IRQ_PRECISE] = 1'b1;
    end
    if (instr_bus_err_flag_err_issue) begin
      istat_nxt[`FSC_IRQ_INSTR_ERR] = 1'b1;
    end
    if (stack_violation) begin
      istat_nxt[`FSC_IRQ_STKVIO] = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= `FSC_STATUS_RST;
      pend_r <= 1'b0;
      istat_r <= `FSC_MASK_RST;
      imask_r <= `FSC_MASK_RST;
      prio_r <= `FSC_PRIO_RST;
      bus_fault_activate <= 1'b0;
      imprecise_pending <= 1'b0;
      irq <= 1'b0;
    end else if (clk_en) begin
      status_r <= status_nxt;
      istat_r <= istat_nxt;
      irq <= |(istat_nxt & imask_r);
      if (wr_acc && paddr == `FSC_OFF_IRQ_MASK) begin
        imask_r <= pwdata[3:0];
      end
      if (wr_acc && paddr == `FSC_OFF_PRIO) begin
        prio_r <= pwdata[7:0];
      end
      // Deferred activation of imprecise fault
      bus_fault_activate <= 1'b0;
      if ((dbus_err_imprecise || pend_r) && may_activate) begin
        pend_r <= 1'b0;
        bus_fault_activate <= 1'b1;
        imprecise_pending <= 1'b0;
      end else if (dbus_err_imprecise) begin
        pend_r <= 1'b1;
        imprecise_pending <= 1'b1;
      end
    end
  end

  // APB: one wait state for all accesses, fault address reads from the store register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      if (psel && penable && !pready) begin
        pready <= 1'b1;
        pslverr <= !known(paddr);
        prdata <= 32'h00000000;
        if (!pwrite) begin
          case (paddr)
            `FSC_OFF_STATUS: prdata <= {16'h0000, status_r};
            `FSC_OFF_BFAR: prdata <= addr_rdata;
            `FSC_OFF_MMFAR: prdata <= addr_rdata;
            `FSC_OFF_PEND: prdata <= {31'h00000000, pend_r};
            `FSC_OFF_IRQ_STAT: prdata <= {28'h0000000, istat_r};
            `FSC_OFF_IRQ_MASK: prdata <= {28'h0000000, imask_r};
            `FSC_OFF_PRIO: prdata <= {24'h000000, prio_r};
            default: prdata <= 32'h00000000;
          endcase
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- verif/fsc_core_model.sv ----
// Core-side fault event source for the fault status block
`timescale 1ns/1ps
`default_nettype none
module fsc_core_model (
  input wire logic pclk,
  output logic imp,
  output logic prec,
  output logic ierr,
  output logic mf,
  output logic stk,
  output logic [31:0] daddr,
  output logic [31:0] maddr,
  output logic [7:0] prio
);
  initial begin
    {imp, prec, ierr, mf, stk} = 5'h00;
    daddr = 32'h0;
    maddr = 32'h0;
    prio = 8'h00;
  end
  // One-cycle event; address lines scrambled once released
  task fire(input logic [4:0] k, input logic [31:0] a);
    @(posedge pclk);
    {imp, prec, ierr, mf, stk} <= k;
    daddr <= a;
    maddr <= a;
    @(posedge pclk);
    {imp, prec, ierr, mf, stk} <= 5'h00;
    daddr <= ~a;
    maddr <= ~a;
  endtask
  // Execution priority as seen by the fault block
  task set_prio(input logic [7:0] p);
    prio <= p;
  endtask
endmodule
`default_nettype wire

// ---- verif/fsc_fault_status_monitor.sv ----
// Bus and deferral checks for the fault status block
`timescale 1ns/1ps
`default_nettype none
module fsc_fault_status_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [11:0] paddr,
  input wire logic dbus_err_imprecise,
  input wire logic [7:0] cur_priority,
  input wire logic bus_fault_activate,
  input wire logic imprecise_pending
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  a_ready_one_wait: assert property (s_wait |=> pready) else $error("ready late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
  a_ready_in_access: assert property (pready |-> psel && penable) else $error("ready outside access");
  a_err_unmapped: assert property (pready && paddr > 12'h018 |-> pslverr) else $error("no error on hole");
  a_act_not_urgent: assert property (bus_fault_activate |-> $past(cur_priority) != 8'h00) else $error("early activate");
  a_act_has_cause: assert property (bus_fault_activate |-> $past(imprecise_pending) || $past(dbus_err_imprecise))
    else $error("activate without fault");
  a_pend_held: assert property (imprecise_pending && cur_priority == 8'h00 |=> imprecise_pending) else $error("pend lost");
  a_pend_cause: assert property ($rose(imprecise_pending) |-> $past(dbus_err_imprecise)) else $error("pend no cause");
  a_act_bound: assert property (imprecise_pending && cur_priority == 8'hff |-> ##[0:2] bus_fault_activate) else $error("no activate");
endmodule
bind fsc_fault_status fsc_fault_status_monitor u_mon (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .paddr,
  .dbus_err_imprecise, .cur_priority, .bus_fault_activate, .imprecise_pending);
`default_nettype wire

// ---- verif/tb.sv ----
// Testbench for the fault status block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [4:0] f;
  logic [31:0] da, ma;
  logic [7:0] cp;
  logic ce = 1'b1;
  logic act, ipend, qe;
  logic act_seen = 1'b0;
  int err_count = 0;
  int check_count = 0;
  fsc_core_model cm (.pclk(pclk), .imp(f[4]), .prec(f[3]), .ierr(f[2]), .mf(f[1]), .stk(f[0]),
    .daddr(da), .maddr(ma), .prio(cp));
  fsc_fault_status dut (.pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dbus_err_imprecise(f[4]), .dbus_err_precise(f[3]), .dbus_err_addr(da), .instr_bus_err_flag_err_issue(f[2]),
    .mem_fault(f[1]), .mem_fault_addr(ma), .stack_violation(f[0]), .cur_priority(cp),
    .bus_fault_activate(act), .imprecise_pending(ipend), .irq(irq));
  always @(posedge pclk) begin
    if (act === 1'b1) act_seen <= 1'b1;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    qe = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task wrap_up;
    $display("checks=%0d mismatches=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    pclk = 0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    err_count++;
    wrap_up;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h000, 32'h0);
    cm.fire(5'h08, 32'h2000_0040);
    rd(12'h000, 32'h200);
    rd(12'h004, 32'h2000_0040);
    $display("precise done");
    cm.fire(5'h10, 32'h3000_0000);
    rd(12'h000, 32'h600);
    rd(12'h004, 32'h2000_0040);
    rd(12'h00c, 32'h1);
    chk({31'h0, ipend}, 32'h1);
    apb(1'b1, 12'h018, 32'h40);
    rd(12'h018, 32'h40);
    cm.set_prio(8'hff);
    rd(12'h00c, 32'h0);
    chk({31'h0, ipend}, 32'h0);
    chk({31'h0, act_seen}, 32'h1);
    cm.set_prio(8'h00);
    $display("imprecise done");
    cm.fire(5'h04, 32'h4000_0000);
    rd(12'h000, 32'h700);
    rd(12'h004, 32'h2000_0040);
    cm.fire(5'h03, 32'h5000_0000);
    rd(12'h000, 32'h710);
    rd(12'h008, 32'h0);
    cm.fire(5'h02, 32'h6000_0010);
    rd(12'h000, 32'h790);
    rd(12'h008, 32'h6000_0010);
    $display("capture done");
    apb(1'b1, 12'h000, 32'h0);
    rd(12'h000, 32'h790);
    apb(1'b1, 12'h000, 32'h80);
    rd(12'h000, 32'h710);
    apb(1'b1, 12'h000, 32'hffff_ffff);
    rd(12'h000, 32'h0);
    ce <= 1'b0;
    cm.fire(5'h04, 32'h7000_0000);
    ce <= 1'b1;
    rd(12'h000, 32'h0);
    $display("clear done");
    rd(12'h010, 32'hf);
    apb(1'b1, 12'h014, 32'h2);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, 12'h010, 32'h2);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    rd(12'h010, 32'hd);
    rd(12'h020, 32'h0);
    chk({31'h0, qe}, 32'h1);
    $display("irq and bus done");
    wrap_up;
  end
endmodule
`default_nettype wire
